// *** shared/ops_pkg.sv ***
// Constants and types of the optical power-state and conciliation block.
// Assumes one 250 MHz clock and a same-clock wake-up manager and PHY port.
//
// Behaviour
// - Sleep power state splits into prepare-sleep and deep-sleep states.
// - Normal power state maps onto one internal normal state.
// - Each powerdown flag assignment raises indication and request events, both values.
// - Powerdown flag is true only while the PHY is powered down.
// - Supply-off flag follows the supply power-off mode on every change.
// - Sleep-inhibit value of the last wake forward request is held.
// - Entering or leaving normal raises wake forward indication with in-normal flag.
// - Wake event generation raises a wake indication; none while it is false.
// - Signal-detect latch stores OK as true and FAIL as false.
// - Powerdown request latch stores the last requested powerdown value.
// - Packet, acknowledge and signal-detect indications come from PHY registers.
// - A send request writes the PHY register to launch the packet.
// - Register bits 12, 13 and 15 are message, remote and request toggles.
// - Packet toggle id is true when message toggle equals request bit.
// - A local CRC16 function builds and checks sleep and wake packets.
// - Sleep status reads normal when powerdown is false, sleep when true.
// - Acknowledge when remote received toggle equals the packet toggle id.
package ops_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQS = 8'h08;
  localparam logic [7:0] OFS_IRQM = 8'h0C;
  localparam int CTRL_WAKE = 0;
  localparam int IRQ_W = 5;
  localparam int IRQ_PD = 0;
  localparam int IRQ_PKT = 1;
  localparam int IRQ_ACK = 2;
  localparam int IRQ_SD = 3;
  localparam int IRQ_SUP = 4;
  localparam int MSG_TGL = 12;
  localparam int REM_TGL = 13;
  localparam int REQ_TGL = 15;
  localparam int PDU_W = 140;
  localparam int CRC_SPAN = 124;
  localparam logic [15:0] CRC_POLY = 16'h3D65;
  // Company identifier of the packet header; the value is arbitrary.
  localparam logic [23:0] CID_VAL = 24'h5A3C96;
  localparam logic [15:0] PROTO_ID = 16'h0001;
  localparam logic [15:0] TYPE_MAX = 16'h0003;
  localparam int PREP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PREP_CYCLES = (PREP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] ST_CODE_NORMAL = 2'h0;
  localparam logic [1:0] ST_CODE_PREP = 2'h1;
  localparam logic [1:0] ST_CODE_DEEP = 2'h2;
  typedef enum logic [1:0] {ST_NORMAL, ST_PREP, ST_DEEP} ops_state_t;
  typedef struct packed {
    logic ind_valid;
    logic req_valid;
    logic value;
  } ops_pd_evt_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ops_mmd_wr_t;
endpackage

// *** verilog/ops_core.sv ***
// Power-state tracking and conciliation toward the optical PHY registers.
// Assumes wake-up manager and PHY register port run on core_clk_in.
`timescale 1ns/1ps
module ops_core
  import ops_pkg::*;
#(
  parameter int PREP_CNT = PREP_CYCLES
) (
  // Clock and reset.
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  // AHB-Lite slave.
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic [31:0]            hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // Wake-up manager requests.
  input  wire logic              pd_req_valid_in,
  input  wire logic              pd_req_value_in,
  input  wire logic              wake_fwd_req_valid_in,
  input  wire logic              wake_fwd_inhibit_in,
  input  wire logic              send_pkt_valid_in,
  input  wire logic [1:0]        send_pkt_type_in,
  input  wire logic              supply_off_in,
  // PHY side.
  input  wire logic              rx_detect_valid_in,
  input  wire logic              rx_detect_ok_in,
  input  wire logic [15:0]       mmd_reg_in,
  input  wire logic              sd_reg_in,
  input  wire logic              rx_pdu_valid_in,
  input  wire logic [PDU_W-1:0]  rx_pdu_in,
  // Indications.
  output ops_pd_evt_t            pd_evt_out,
  output logic                   wake_fwd_ind_out,
  output logic                   in_normal_flag_out,
  output logic                   wake_ind_out,
  output logic                   sleep_status_out,
  output logic                   sleep_status_valid_out,
  output logic                   pkt_ind_out,
  output logic [1:0]             pkt_type_out,
  output logic                   pkt_ack_out,
  output logic                   sd_ind_out,
  output logic                   sd_value_out,
  output ops_mmd_wr_t            mmd_wr_out,
  output logic [PDU_W-1:0]       tx_pdu_out,
  output logic                   irq_out
);

  localparam logic [15:0] PREP_LAST = 16'(PREP_CNT - 1);

  // One CRC16 function serves both building and checking packets, as two separate instances.
  function automatic logic [15:0] crc16(input logic [CRC_SPAN-1:0] d);
    logic [15:0] s;
    logic        fb;
    s = 16'h0000;
    for (int i = 0; i < CRC_SPAN; i++) begin
      fb = d[i] ^ s[15];
      s = {s[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return s;
  endfunction

  function automatic logic [PDU_W-1:0] pdu_build(input logic [1:0] t);
    logic [CRC_SPAN-1:0] b;
    b = '0;
    b[11:0] = CID_VAL[23:12];
    b[23:12] = CID_VAL[11:0];
    b[43:28] = PROTO_ID;
    b[59:44] = {14'h0000, t};
    return {crc16(b), b};
  endfunction

  // Supply-off comes from a pin and is synchronised.
  logic sup_s1_r;
  logic sup_s2_r;
  logic sup_r;

  // State and latches.
  ops_state_t  st_r;
  ops_state_t  st_nxt;
  logic [15:0] prep_cnt_r;
  logic        pd_r;
  logic        inhibit_r;
  logic        sd_latch_r;
  logic        pd_req_r;
  logic        tgl_id_r;
  logic        ack_pend_r;
  logic        sd_prev_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;

  // Bus.
  logic        wr_pend_r;
  logic [7:0]  wr_ofs_r;
  logic [31:0] rd_data;

  // Decode.
  wire logic addr_ph = hsel_in & htrans_in[1] & hready_in;
  wire logic [7:0] a_ofs = haddr_in[7:0];
  wire logic sw_wake = wr_pend_r & (wr_ofs_r == OFS_CTRL)
                       & hwdata_in[CTRL_WAKE];
  wire logic irq_w1c_hit = wr_pend_r & (wr_ofs_r == OFS_IRQS);
  wire logic irq_msk_hit = wr_pend_r & (wr_ofs_r == OFS_IRQM);

  wire logic is_normal = (st_r == ST_NORMAL);
  wire logic nxt_normal = (st_nxt == ST_NORMAL);
  wire logic prep_done = (prep_cnt_r == PREP_LAST);
  wire logic go_sleep = pd_req_valid_in & pd_req_value_in
                        & ~inhibit_r;
  wire logic stay_req = pd_req_valid_in ? pd_req_value_in : pd_req_r;
  wire logic wake_gen = ~is_normal & (sd_latch_r | sw_wake);
  wire logic pd_nxt = (st_nxt == ST_DEEP);
  wire logic pd_change = (pd_nxt != pd_r);
  wire logic sup_change = (sup_s2_r != sup_r);

  wire logic tgl_eq = (mmd_reg_in[MSG_TGL] == mmd_reg_in[REQ_TGL]);
  wire logic ack_hit = ack_pend_r
                       & (mmd_reg_in[REM_TGL] == tgl_id_r);
  wire logic sd_change = (sd_reg_in != sd_prev_r);

  wire logic [15:0] rx_crc = crc16(rx_pdu_in[CRC_SPAN-1:0]);
  wire logic rx_cid_ok = (rx_pdu_in[11:0] == CID_VAL[23:12])
                         & (rx_pdu_in[23:12] == CID_VAL[11:0]);
  wire logic rx_ok = rx_pdu_valid_in & rx_cid_ok
                     & (rx_pdu_in[43:28] == PROTO_ID)
                     & (rx_pdu_in[59:44] <= TYPE_MAX)
                     & (rx_pdu_in[PDU_W-1:CRC_SPAN] == rx_crc);

  wire logic [IRQ_W-1:0] irq_ev = {sup_change, sd_change, ack_hit,
                                   rx_ok, pd_change};

  // Power state machine.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_NORMAL: begin
        if (go_sleep) begin
          st_nxt = ST_PREP;
        end
      end
      ST_PREP: begin
        if (wake_gen | ~stay_req) begin
          st_nxt = ST_NORMAL;
        end else if (prep_done) begin
          st_nxt = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (wake_gen | ~stay_req) begin
          st_nxt = ST_NORMAL;
        end
      end
      default: begin
        st_nxt = ST_NORMAL;
      end
    endcase
  end

  // State code for the status register.
  logic [1:0] st_code;
  always_comb begin
    case (st_r)
      ST_NORMAL: st_code = ST_CODE_NORMAL;
      ST_PREP:   st_code = ST_CODE_PREP;
      ST_DEEP:   st_code = ST_CODE_DEEP;
      default:   st_code = ST_CODE_NORMAL;
    endcase
  end

  // Read mux, sampled in the address phase.
  always_comb begin
    case (a_ofs)
      OFS_STAT: rd_data = {23'h000000, ack_pend_r, tgl_id_r, pd_req_r,
                           sd_latch_r, inhibit_r, sup_r, pd_r,
                           st_code};
      OFS_IRQS: rd_data = {27'h0000000, irq_stat_r};
      OFS_IRQM: rd_data = {27'h0000000, irq_mask_r};
      default:  rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
    end else begin
      sup_s1_r <= supply_off_in;
      sup_s2_r <= sup_s1_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st_r <= ST_NORMAL;
      prep_cnt_r <= 16'h0000;
      pd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pd_r <= pd_nxt;
      if (st_r != ST_PREP) begin
        prep_cnt_r <= 16'h0000;
      end else if (!prep_done) begin
        prep_cnt_r <= prep_cnt_r + 16'h0001;
      end
    end
  end

  // Latched parameters of the incoming requests.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sup_r <= 1'b0;
      inhibit_r <= 1'b0;
      sd_latch_r <= 1'b0;
      pd_req_r <= 1'b0;
      sd_prev_r <= 1'b0;
    end else begin
      sup_r <= sup_s2_r;
      sd_prev_r <= sd_reg_in;
      if (wake_fwd_req_valid_in) begin
        inhibit_r <= wake_fwd_inhibit_in;
      end
      if (rx_detect_valid_in) begin
        sd_latch_r <= rx_detect_ok_in;
      end
      if (pd_req_valid_in) begin
        pd_req_r <= pd_req_value_in;
      end
    end
  end

  // Event outputs toward the wake-up manager and the PHY.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pd_evt_out <= '0;
      wake_fwd_ind_out <= 1'b0;
      in_normal_flag_out <= 1'b1;
      wake_ind_out <= 1'b0;
      sleep_status_out <= 1'b0;
      sleep_status_valid_out <= 1'b0;
      sd_ind_out <= 1'b0;
      sd_value_out <= 1'b0;
    end else begin
      pd_evt_out.ind_valid <= pd_change;
      pd_evt_out.req_valid <= pd_change;
      pd_evt_out.value <= pd_nxt;
      wake_fwd_ind_out <= (nxt_normal != is_normal);
      in_normal_flag_out <= nxt_normal;
      wake_ind_out <= wake_gen;
      sleep_status_out <= pd_nxt;
      sleep_status_valid_out <= pd_change | sup_change;
      sd_ind_out <= sd_change;
      if (sd_change) begin
        sd_value_out <= sd_reg_in;
      end
    end
  end

  // Packet send, acknowledge and receive.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      tgl_id_r <= 1'b0;
      ack_pend_r <= 1'b0;
      pkt_ack_out <= 1'b0;
      mmd_wr_out <= '0;
      tx_pdu_out <= '0;
      pkt_ind_out <= 1'b0;
      pkt_type_out <= 2'h0;
    end else begin
      pkt_ack_out <= ack_hit;
      mmd_wr_out.valid <= send_pkt_valid_in;
      pkt_ind_out <= rx_ok;
      if (rx_ok) begin
        pkt_type_out <= rx_pdu_in[45:44];
      end
      // A new send wins over the acknowledge of the previous one.
      if (send_pkt_valid_in) begin
        tgl_id_r <= tgl_eq;
        ack_pend_r <= 1'b1;
        tx_pdu_out <= pdu_build(send_pkt_type_in);
        mmd_wr_out.data <= mmd_reg_in
                           ^ (16'h0001 << REQ_TGL);
      end else if (ack_hit) begin
        ack_pend_r <= 1'b0;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata_out <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_ph & hwrite_in;
      if (addr_ph) begin
        wr_ofs_r <= a_ofs;
        hrdata_out <= rd_data;
      end
    end
  end

  // Sticky status: an event in the clearing cycle stays set.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (irq_w1c_hit) begin
        irq_stat_r <= (irq_stat_r & ~hwdata_in[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      if (irq_msk_hit) begin
        irq_mask_r <= hwdata_in[IRQ_W-1:0];
      end
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign irq_out = |(irq_stat_r & irq_mask_r);

endmodule // ops_core

// *** testbench/ops_core_assertions.sv ***
// Concurrent checks on the ports of ops_core.
// Assumes one clock domain and the package compiled before this file.
`timescale 1ns/1ps
module ops_core_chk
  import ops_pkg::*;
#(
  parameter int PREP_CNT = PREP_CYCLES
) (
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        send_pkt_valid_in,
  input wire logic [15:0] mmd_reg_in,
  input wire logic        sd_reg_in,
  input wire logic        sd_ind_out,
  input ops_pd_evt_t      pd_evt_out,
  input wire logic        wake_fwd_ind_out,
  input wire logic        in_normal_flag_out,
  input ops_mmd_wr_t      mmd_wr_out
);
  // Sleep entry may be undone by a wake while still preparing.
  localparam int PD_MAX = PREP_CNT + 4;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_launch;
    mmd_wr_out.valid && mmd_wr_out.data[15] != $past(mmd_reg_in[15])
      && mmd_wr_out.data[14:0] == $past(mmd_reg_in[14:0]);
  endsequence
  a_bus_okay: assert property (hreadyout_out && !hresp_out) else $error("bus not ready okay");
  a_pd_pair: assert property (pd_evt_out.ind_valid == pd_evt_out.req_valid)
    else $error("powerdown events not paired");
  a_pd_not_normal: assert property (pd_evt_out.ind_valid && pd_evt_out.value
    |-> !in_normal_flag_out) else $error("powerdown true in normal");
  a_fwd_on_change: assert property ($changed(in_normal_flag_out)
    |-> ##[0:1] wake_fwd_ind_out) else $error("no wake forward on change");
  a_send_write: assert property (send_pkt_valid_in |=> s_launch)
    else $error("send did not write register");
  a_no_stray_write: assert property (!send_pkt_valid_in |=> !mmd_wr_out.valid)
    else $error("register write without send");
  a_sleep_reaches_pd: assert property ($fell(in_normal_flag_out)
    |-> ##[1:PD_MAX] (pd_evt_out.ind_valid || in_normal_flag_out))
    else $error("deep sleep not reached");
  a_sd_follow: assert property ($changed(sd_reg_in) |-> ##[1:2] sd_ind_out)
    else $error("signal detect not indicated");
endmodule // ops_core_chk

// *** testbench/ops_phy_model.sv ***
// Behavioural PHY register 3.500 that echoes the packet identifier.
// Assumes the write port is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module ops_phy_model
  import ops_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input ops_mmd_wr_t      wr_in,
  input wire logic [7:0]  dly_in,
  output logic [15:0]     reg_out
);
  logic [7:0] cnt_r;
  logic       id_r;
  // The remote toggle answers after dly_in cycles, so slow partners are modelled too.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_out <= 16'h0000;
      cnt_r   <= 8'h00;
      id_r    <= 1'b0;
    end else if (wr_in.valid) begin
      reg_out <= wr_in.data;
      id_r    <= wr_in.data[MSG_TGL] != wr_in.data[REQ_TGL];
      cnt_r   <= dly_in;
    end else if (cnt_r == 8'h01) begin
      reg_out[REM_TGL] <= id_r;
      cnt_r            <= 8'h00;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // ops_phy_model

// *** testbench/testbench.sv ***
// Self-checking bench for ops_core with a PHY register model.
// Assumes the package, checker and model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
`define WAITFOR(c) begin wn = 0; while (!(c) && wn < 200) begin @(negedge clk); wn++; end \
  if (wn >= 200) begin error_cnt++; complete_run(); end end
`define PULSE(s) begin @(posedge clk); s <= 1'b1; @(posedge clk); s <= 1'b0; end
module testbench;
  import ops_pkg::*;
  localparam int PREP_CNT = 20;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_v = 1'b0, id;
  logic [1:0]  htrans = 2'h0, pkt_type = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        pd_v = 1'b0, pd_val = 1'b0, wf_v = 1'b0, wf_inh = 1'b0, snd_v = 1'b0;
  logic        sup_off = 1'b0, rxd_v = 1'b0, rxd_ok = 1'b0, sd_reg = 1'b0;
  logic        hready, hresp, wf_ind, in_norm, wake_ind, sleep_st, pkt_ack, sd_ind, sd_val, irq;
  logic        ss_v, pkt_ind;
  logic [1:0]  pkt_typ;
  logic [PDU_W-1:0] rx_pdu = '0, tx_pdu, bad;
  logic [15:0] phy_reg;
  logic [7:0]  dly = 8'h01;
  ops_pd_evt_t pd_evt;
  ops_mmd_wr_t mmd_wr;
  int          error_cnt = 0, total_checks = 0, wn, i;
  always #2 clk = ~clk;
  ops_core #(.PREP_CNT(PREP_CNT)) u_ops_core (.core_clk_in(clk), .reset_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .pd_req_valid_in(pd_v), .pd_req_value_in(pd_val),
    .wake_fwd_req_valid_in(wf_v), .wake_fwd_inhibit_in(wf_inh), .send_pkt_valid_in(snd_v),
    .send_pkt_type_in(pkt_type), .supply_off_in(sup_off), .rx_detect_valid_in(rxd_v),
    .rx_detect_ok_in(rxd_ok), .mmd_reg_in(phy_reg), .sd_reg_in(sd_reg), .rx_pdu_valid_in(rx_v),
    .rx_pdu_in(rx_pdu), .pd_evt_out(pd_evt), .wake_fwd_ind_out(wf_ind),
    .in_normal_flag_out(in_norm), .wake_ind_out(wake_ind), .sleep_status_out(sleep_st),
    .sleep_status_valid_out(ss_v), .pkt_ind_out(pkt_ind), .pkt_type_out(pkt_typ),
    .pkt_ack_out(pkt_ack), .sd_ind_out(sd_ind), .sd_value_out(sd_val), .mmd_wr_out(mmd_wr),
    .tx_pdu_out(tx_pdu),
    .irq_out(irq));
  ops_phy_model u_ops_phy_model (.clk_in(clk), .rst_n_in(rst_n), .wr_in(mmd_wr),
    .dly_in(dly), .reg_out(phy_reg));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_rdy;
    wn = 0;
    do begin @(posedge clk); wn++; end while (hready !== 1'b1 && wn < 50);
    if (wn >= 50) begin error_cnt++; complete_run(); end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // Reference packet built bit by bit from the package constants, not from the design.
  function automatic logic [PDU_W-1:0] exp_pdu(input logic [1:0] t);
    logic [PDU_W-1:0] p;
    logic [15:0]      s;
    p = '0;
    s = 16'h0000;
    p[23:0] = {CID_VAL[11:0], CID_VAL[23:12]};
    p[43:28] = PROTO_ID;
    p[45:44] = t;
    for (int k = 0; k < CRC_SPAN; k++) begin
      if (p[k] ^ s[15]) begin
        s = {s[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        s = {s[14:0], 1'b0};
      end
    end
    p[PDU_W-1:CRC_SPAN] = s;
    return p;
  endfunction
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, OFS_STAT, 0); `CHK("state", 32'h0, rd & 32'h7)
    `CHK("normal", 1'b1, in_norm)
    bus(0, 8'h40, 0); `CHK("unmapped", 32'h0, rd)
    $display("end reset test");
    wf_inh <= 1'b1; `PULSE(wf_v)
    pd_val <= 1'b1; `PULSE(pd_v)
    bus(0, OFS_STAT, 0); `CHK("inhibit", 32'h50, rd & 32'h53)
    wf_inh <= 1'b0; `PULSE(wf_v)
    `PULSE(pd_v)
    `WAITFOR(wf_ind === 1'b1) `CHK("leave", 1'b0, in_norm)
    bus(0, OFS_STAT, 0); `CHK("prep", 32'h1, rd & 32'h7)
    `WAITFOR(pd_evt.ind_valid === 1'b1) `CHK("pdreq", 1'b1, pd_evt.req_valid)
    `CHK("pdval", 1'b1, pd_evt.value)
    bus(0, OFS_STAT, 0); `CHK("deep", 32'h6, rd & 32'h7)
    `CHK("sleep", 1'b1, sleep_st)
    $display("end sleep test");
    bus(1, OFS_IRQS, 32'h1E); bus(0, OFS_IRQS, 0); `CHK("irqpd", 32'h1, rd & 32'h1)
    bus(1, OFS_IRQM, 32'h1F); @(negedge clk); `CHK("irqon", 1'b1, irq)
    bus(1, OFS_IRQM, 32'h0); @(negedge clk); `CHK("mask", 1'b0, irq)
    bus(1, OFS_IRQM, 32'h1F);
    bus(1, OFS_IRQS, 32'h1F); @(negedge clk); `CHK("clear", 1'b0, irq)
    $display("end irq test");
    rxd_ok <= 1'b1; `PULSE(rxd_v)
    `WAITFOR(wake_ind === 1'b1) `WAITFOR(in_norm === 1'b1)
    `WAITFOR(pd_evt.ind_valid === 1'b1) `CHK("pdfalse", 1'b0, pd_evt.value)
    bus(0, OFS_STAT, 0); `CHK("sdok", 32'h20, rd & 32'h27)
    rxd_ok <= 1'b0; `PULSE(rxd_v)
    pd_val <= 1'b0; `PULSE(pd_v)
    bus(0, OFS_STAT, 0); `CHK("sdfail", 32'h0, rd & 32'h60)
    sup_off <= 1'b1; `WAITFOR(ss_v === 1'b1) `CHK("sstat", 1'b0, sleep_st)
    bus(0, OFS_STAT, 0); `CHK("supply", 32'h8, rd & 32'h8)
    sd_reg <= 1'b1; `WAITFOR(sd_ind === 1'b1) `CHK("sdreg", 1'b1, sd_val)
    $display("end wake test");
    for (i = 0; i < 4; i++) begin
      dly <= i[0] ? 8'h28 : 8'h01;
      pkt_type <= i[1:0];
      id = phy_reg[12] == phy_reg[15];
      `PULSE(snd_v)
      `WAITFOR(mmd_wr.valid === 1'b1) `CHK("req", ~phy_reg[15], mmd_wr.data[15])
      `CHK("pdu", exp_pdu(i[1:0]), tx_pdu)
      if (i[0]) begin bus(0, OFS_STAT, 0); `CHK("id", id, rd[7]) end
      `WAITFOR(pkt_ack === 1'b1) `CHK("ack", id, phy_reg[13])
    end
    $display("end send test");
    rx_pdu <= exp_pdu(2'h2); `PULSE(rx_v)
    @(negedge clk); `CHK("pkt", 1'b1, pkt_ind)
    `CHK("ptype", 2'h2, pkt_typ)
    bad = exp_pdu(2'h1);
    bad[PDU_W-1] = ~bad[PDU_W-1];
    rx_pdu <= bad; `PULSE(rx_v)
    @(negedge clk); `CHK("badcrc", 1'b0, pkt_ind)
    `CHK("pheld", 2'h2, pkt_typ)
    $display("end receive test");
    complete_run();
  end
endmodule // testbench
bind ops_core ops_core_chk #(.PREP_CNT(PREP_CNT)) u_ops_core_chk (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .send_pkt_valid_in(send_pkt_valid_in), .mmd_reg_in(mmd_reg_in), .sd_reg_in(sd_reg_in),
  .pd_evt_out(pd_evt_out), .wake_fwd_ind_out(wake_fwd_ind_out),
  .in_normal_flag_out(in_normal_flag_out), .mmd_wr_out(mmd_wr_out), .sd_ind_out(sd_ind_out));
